// ---- hw/bps_buck_pwm_skip_sequencer.sv ----
// Switch sequencer, light-load control, protection and reset timer
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module bps_buck_pwm_skip_sequencer #(
  parameter int unsigned POR_DELAY_TICKS = bps_pkg::POR_TICKS
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // Control pins
  input  wire logic        enable_i,
  input  wire logic        mode_skip_i,
  input  wire logic        reset_request_in_i,
  // Power stage indications
  input  wire logic        input_undervoltage_lockout_i,
  input  wire logic        thermal_hot_i,
  input  wire logic        pwm_comp_trip_i,
  input  wire logic        overcurrent_comparator_i,
  input  wire logic        short_circuit_comparator_i,
  input  wire logic        skip_current_comp_i,
  input  wire logic        out_above_skip_i,
  input  wire logic        out_below_nominal_i,
  input  wire logic        out_below_skip_i,
  input  wire logic        zero_cross_i,
  input  wire logic        output_in_window_i,
  input  wire logic        dropout_i,
  // Switch and soft-start drive
  output logic             hs_on_o,
  output logic             ls_on_o,
  output logic             discharge_o,
  output logic             soft_start_run_o,
  // Open-drain reset output
  output logic             reset_out_o,
  output logic             reset_out_oe_o,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o
);
  import bps_pkg::*;

  localparam int PIN_W = 15;
  localparam int POR_W = $clog2(POR_DELAY_TICKS + 1);

  logic             rst_meta_reg;
  logic             rst_sync_b;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic en_s, mode_s, req_s, input_undervoltage_lockout_s, hot_s, trip_s, ocp_s, sc_s;
  logic skip_comp_s, above_s, below_nom_s, below_lo_s, zc_s;
  logic output_in_window_s, dropout_s;
  logic [4:0]       osc_cnt_reg;
  logic [1:0]       div_cnt_reg;
  logic             osc_wrap;
  logic             tick;
  bps_state_t       state_reg;
  bps_state_t       state_next;
  logic             fault;
  logic             skip_ok;
  logic             go_skip;
  logic             in_pwm;
  logic             in_skip;
  logic             running;
  logic [ZC_W-1:0]  zc_cnt_reg;
  logic             zc_seen_reg;
  logic             hold_reg;
  logic [WAKE_W-1:0] wake_cnt_reg;
  logic [POR_W-1:0] por_cnt_reg;
  logic             force_pwm_reg;
  logic             bus_req;
  logic [31:0]      status_word;

  //////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_b   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_b   <= rst_meta_reg;
    end
  end

  assign pin_raw = {enable_i, mode_skip_i, reset_request_in_i,
                    input_undervoltage_lockout_i, thermal_hot_i,
                    pwm_comp_trip_i, overcurrent_comparator_i,
                    short_circuit_comparator_i, skip_current_comp_i,
                    out_above_skip_i, out_below_nominal_i,
                    out_below_skip_i, zero_cross_i, output_in_window_i,
                    dropout_i};

  generate
    for (genvar i = 0; i < PIN_W; i++) begin : g_sync
      always_ff @(posedge mclk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          pin_meta_reg[i] <= 1'b0;
          pin_sync_reg[i] <= 1'b0;
        end else begin
          pin_meta_reg[i] <= pin_raw[i];
          pin_sync_reg[i] <= pin_meta_reg[i];
        end
      end
    end
  endgenerate

  assign {en_s, mode_s, req_s, input_undervoltage_lockout_s, hot_s, trip_s, ocp_s, sc_s,
          skip_comp_s, above_s, below_nom_s, below_lo_s, zc_s,
          output_in_window_s, dropout_s} = pin_sync_reg;

  //////////////////////////////////////////////////////////////////////////
  // Oscillator, divided by three while feedback is low

  assign osc_wrap = (osc_cnt_reg == 5'(OSC_DIV - 1));
  assign tick     = osc_wrap &&
                    (!sc_s || div_cnt_reg == 2'(SC_DIVIDE - 1));

  always_ff @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      osc_cnt_reg <= 5'h0;
    end else if (osc_wrap) begin
      osc_cnt_reg <= 5'h0;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 5'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      div_cnt_reg <= 2'h0;
    end else if (!sc_s) begin
      div_cnt_reg <= 2'h0;
    end else if (osc_wrap) begin
      div_cnt_reg <= (div_cnt_reg == 2'(SC_DIVIDE - 1)) ?
                     2'h0 : div_cnt_reg + 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Switch sequencing

  assign fault   = !en_s || input_undervoltage_lockout_s || hot_s;
  assign skip_ok = mode_s && !force_pwm_reg;
  assign in_pwm  = (state_reg == ST_PWM_HS) || (state_reg == ST_PWM_LS);
  assign in_skip = (state_reg == ST_SKIP_HS) || (state_reg == ST_SKIP_LS) ||
                   (state_reg == ST_SKIP_IDLE);
  assign running = in_pwm || in_skip;
  assign go_skip = skip_ok && (zc_seen_reg || zc_s) &&
                   (zc_cnt_reg == ZC_W'(ZC_ENTRY_COUNT - 1));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        state_next = ST_WAKE;
      end
      ST_WAKE: begin
        // Undivided oscillator: low feedback must not stretch the wake-up
        if (osc_wrap && wake_cnt_reg == WAKE_W'(WAKE_TICKS - 1)) begin
          state_next = ST_PWM_LS;
        end
      end
      ST_PWM_HS: begin
        // Dropout keeps the switch on; overcurrent still ends the pulse
        if (ocp_s || (trip_s && !dropout_s)) begin
          state_next = ST_PWM_LS;
        end
      end
      ST_PWM_LS: begin
        if (tick) begin
          state_next = go_skip ? ST_SKIP_HS : ST_PWM_HS;
        end
      end
      ST_SKIP_HS: begin
        if (!skip_ok || below_lo_s) begin
          state_next = ST_PWM_LS;
        end else if (ocp_s || skip_comp_s || above_s) begin
          state_next = ST_SKIP_LS;
        end
      end
      ST_SKIP_LS: begin
        if (!skip_ok || below_lo_s) begin
          state_next = ST_PWM_LS;
        end else if (zc_s) begin
          state_next = ST_SKIP_IDLE;
        end
      end
      ST_SKIP_IDLE: begin
        if (!skip_ok || below_lo_s) begin
          state_next = ST_PWM_LS;
        end else if (tick && (!hold_reg || below_nom_s)) begin
          state_next = ST_SKIP_HS;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    if (fault) begin
      state_next = ST_OFF;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Switch drive follows the next state so it lines up with state_reg
  always_ff @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hs_on_o          <= 1'b0;
      ls_on_o          <= 1'b0;
      soft_start_run_o <= 1'b0;
      discharge_o      <= 1'b1;
    end else begin
      hs_on_o <= (state_next == ST_PWM_HS) ||
                 (state_next == ST_SKIP_HS);
      ls_on_o <= (state_next == ST_PWM_LS) ||
                 (state_next == ST_SKIP_LS);
      soft_start_run_o <= (state_next != ST_OFF) &&
                          (state_next != ST_WAKE);
      discharge_o <= !en_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Zero-cross counting and skip hold

  always_ff @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      zc_seen_reg <= 1'b0;
    end else if (!in_pwm || tick) begin
      zc_seen_reg <= 1'b0;
    end else if (zc_s) begin
      zc_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      zc_cnt_reg <= '0;
    end else if (fault || !in_pwm || !skip_ok) begin
      zc_cnt_reg <= '0;
    end else if (tick && state_reg == ST_PWM_LS) begin
      if (go_skip || !(zc_seen_reg || zc_s)) begin
        zc_cnt_reg <= '0;
      end else begin
        zc_cnt_reg <= zc_cnt_reg + ZC_W'(1);
      end
    end
  end

  // Set wins over the restart clear (fault or leaving skip still clears): an overshoot seen while restarting still holds
  always_ff @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hold_reg <= 1'b0;
    end else if (fault || !in_skip) begin
      hold_reg <= 1'b0;
    end else if (above_s) begin
      hold_reg <= 1'b1;
    end else if (state_reg == ST_SKIP_IDLE && tick && below_nom_s) begin
      hold_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Wake-up and reset-output delays

  always_ff @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wake_cnt_reg <= '0;
    end else if (state_reg != ST_WAKE) begin
      wake_cnt_reg <= '0;
    end else if (osc_wrap) begin
      wake_cnt_reg <= wake_cnt_reg + WAKE_W'(1);
    end
  end

  // Any of the clearing terms keeps the counter at zero, so a falling
  // request restarts the delay only inside the window
  always_ff @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      por_cnt_reg    <= '0;
      reset_out_oe_o <= 1'b1;
      reset_out_o    <= 1'b0;
    end else if (fault || !running || req_s || !output_in_window_s) begin
      por_cnt_reg    <= '0;
      reset_out_oe_o <= 1'b1;
    end else if (por_cnt_reg == POR_W'(POR_DELAY_TICKS)) begin
      reset_out_oe_o <= 1'b0;
    end else if (osc_wrap) begin
      por_cnt_reg <= por_cnt_reg + POR_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the access completes

  assign bus_req = avs_read_i || avs_write_i;

  always_comb begin
    status_word = 32'h0;
    status_word[STAT_RUNNING_BIT]  = running;
    status_word[STAT_SKIP_BIT]     = in_skip;
    status_word[STAT_RELEASED_BIT] = !reset_out_oe_o;
    status_word[STAT_HOLD_BIT]     = hold_reg;
    status_word[STAT_ZC_LSB +: ZC_W] = zc_cnt_reg;
    status_word[STAT_ENABLE_BIT]   = en_s;
    status_word[STAT_INPUT_UNDERVOLTAGE_LOCKOUT_BIT]     = input_undervoltage_lockout_s;
    status_word[STAT_HOT_BIT]      = hot_s;
  end

  always_ff @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && avs_waitrequest_o) begin
      case (avs_address_i)
        REG_CTRL_ADDR:   avs_readdata_o <= {31'h0, force_pwm_reg};
        REG_STATUS_ADDR: avs_readdata_o <= status_word;
        default:         avs_readdata_o <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      force_pwm_reg <= CTRL_RESET_VAL;
    end else if (avs_write_i && !avs_waitrequest_o &&
                 avs_address_i == REG_CTRL_ADDR && avs_byteenable_i[0]) begin
      force_pwm_reg <= avs_writedata_i[CTRL_FORCE_PWM_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_sync_b);

  sequence s_wake_begin;
    state_reg == ST_OFF && !fault ##1 state_reg == ST_WAKE;
  endsequence

  sequence s_skip_overshoot;
    state_reg == ST_SKIP_HS && above_s && skip_ok && !below_lo_s && !fault;
  endsequence

  a_hs_cycle_start:
    assert property (state_reg == ST_PWM_LS && tick && !fault |=> hs_on_o)
    else $error("high-side not on at oscillator edge");
  a_ls_after_trip:
    assert property (state_reg == ST_PWM_HS && trip_s && !dropout_s && !fault
                     ##1 !tick |-> ls_on_o && !hs_on_o ##0 !hs_on_o)
    else $error("loop trip did not hand over to low-side");
  a_skip_entry:
    assert property (state_reg == ST_PWM_LS && tick && go_skip && !fault
                     |=> state_reg == ST_SKIP_HS && zc_cnt_reg == '0)
    else $error("skip not entered after zero-cross run");
  a_zc_clear:
    assert property (state_reg == ST_PWM_LS && tick && !zc_seen_reg && !zc_s
                     |=> zc_cnt_reg == '0)
    else $error("zero-cross counter not cleared");
  a_skip_pulse_end:
    assert property (state_reg == ST_SKIP_HS && skip_comp_s && !fault
                     |=> !hs_on_o)
    else $error("skip pulse not ended at light threshold");
  a_skip_overshoot:
    assert property (s_skip_overshoot |=> !hs_on_o && hold_reg)
    else $error("overshoot did not stop the pulse");
  a_skip_restart:
    assert property (state_reg == ST_SKIP_IDLE && hold_reg && tick &&
                     below_nom_s && skip_ok && !below_lo_s && !fault
                     |=> hs_on_o && state_reg == ST_SKIP_HS)
    else $error("skip idle did not restart at nominal");
  a_skip_exit:
    assert property (in_skip && below_lo_s && !fault
                     |=> state_reg == ST_PWM_LS)
    else $error("skip not left on low output");
  a_forced_pwm:
    assert property (!mode_s |=> !in_skip)
    else $error("skip active with mode input low");
  a_ocp_off:
    assert property (hs_on_o && ocp_s |=> !hs_on_o)
    else $error("overcurrent did not end high-side");
  a_sc_divide:
    assert property (tick && sc_s |-> div_cnt_reg == 2'(SC_DIVIDE - 1))
    else $error("switching clock not divided while feedback low");
  a_req_low:
    assert property (req_s |=> reset_out_oe_o [*2])
    else $error("reset request did not pull reset output low");
  a_window_clear:
    assert property (!output_in_window_s |=> reset_out_oe_o && por_cnt_reg == '0)
    else $error("delay counter running outside window");
  a_input_undervoltage_lockout_off:
    assert property (input_undervoltage_lockout_s |=> !hs_on_o && !ls_on_o)
    else $error("switch on during undervoltage lockout");
  a_dropout_on:
    assert property (state_reg == ST_PWM_HS && dropout_s && !ocp_s && !fault
                     |=> hs_on_o)
    else $error("high-side released in dropout");
  a_wake_delay:
    assert property (s_wake_begin |-> !soft_start_run_o [*8])
    else $error("soft-start began before wake delay");
  a_disable_off:
    assert property (!en_s |=> discharge_o && !hs_on_o && !ls_on_o)
    else $error("disable did not stop switching");
  a_hot_off:
    assert property (hot_s |=> state_reg == ST_OFF && !soft_start_run_o)
    else $error("overheat did not shut down");
  a_fault_clear:
    assert property (fault |=> zc_cnt_reg == '0 && !hold_reg &&
                     reset_out_oe_o)
    else $error("fault left sequencing state behind");

endmodule

// ---- hw/bps_pkg.sv ----
// Constants and types shared by the buck switch sequencer
package bps_pkg;

  // Clock and oscillator timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int OSC_PERIOD_NS = 625;
  localparam int OSC_DIV       = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OSC_TICK_NS   = OSC_DIV * CLK_PERIOD_NS;
  localparam int SC_DIVIDE     = 3;

  // Enable wake-up and reset-output delays, counted in oscillator ticks
  localparam int WAKE_TIME_US  = 600;
  localparam int WAKE_TICKS    =
    (WAKE_TIME_US * 1000 + OSC_TICK_NS - 1) / OSC_TICK_NS;
  localparam int WAKE_W        = $clog2(WAKE_TICKS + 1);
  localparam int POR_TIME_MS   = 200;
  localparam int POR_TICKS     =
    (POR_TIME_MS * 1000000 + OSC_TICK_NS - 1) / OSC_TICK_NS;

  // Light-load entry
  localparam int ZC_ENTRY_COUNT = 8;
  localparam int ZC_W           = 4;

  // Register map (byte addresses)
  localparam logic [3:0] REG_CTRL_ADDR   = 4'h0;
  localparam logic [3:0] REG_STATUS_ADDR = 4'h4;
  localparam logic       CTRL_RESET_VAL  = 1'h0;
  localparam int CTRL_FORCE_PWM_BIT      = 0;
  localparam int STAT_RUNNING_BIT        = 0;
  localparam int STAT_SKIP_BIT           = 1;
  localparam int STAT_RELEASED_BIT       = 2;
  localparam int STAT_HOLD_BIT           = 3;
  localparam int STAT_ZC_LSB             = 4;
  localparam int STAT_ENABLE_BIT         = 8;
  localparam int STAT_INPUT_UNDERVOLTAGE_LOCKOUT_BIT           = 9;
  localparam int STAT_HOT_BIT            = 10;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAKE,
    ST_PWM_HS,
    ST_PWM_LS,
    ST_SKIP_HS,
    ST_SKIP_LS,
    ST_SKIP_IDLE
  } bps_state_t;

endpackage

// ---- tb/bps_stage_model.sv ----
// Behavioural power stage: loop, skip and zero-cross comparators
`timescale 1ns/10ps
module bps_stage_model (
  // Clock
  input  wire logic       mclk_i,
  // Switch drive
  input  wire logic       hs_on_i,
  input  wire logic       ls_on_i,
  // Load set by the bench
  input  wire logic [4:0] ton_i,
  input  wire logic       light_i,
  // Comparators
  output logic            trip_o,
  output logic            skip_cur_o,
  output logic            zc_o
);
  logic [5:0] on_cnt_reg;

  always_ff @(posedge mclk_i) begin
    on_cnt_reg <= hs_on_i ? on_cnt_reg + 6'h01 : 6'h00;
  end

  // Comparators drop as soon as the switch opens, as real ones do
  assign trip_o     = hs_on_i & (on_cnt_reg >= {1'h0, ton_i});
  assign skip_cur_o = hs_on_i & (on_cnt_reg >= 6'h03);
  // Light load: low-side current reaches zero before the tick
  assign zc_o       = ls_on_i & light_i;
endmodule

// ---- tb/tb_buck_pwm_skip_sequencer.sv ----
// Self-checking bench for the buck switch sequencer
`timescale 1ns/10ps
`define CHK(a,e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("FAIL %0t %s", $time, tname); end end
`define WT(c,l) begin k = 0; while (!(c) && k < (l)) begin \
  @(posedge clk); k++; end end
module tb_buck_pwm_skip_sequencer;
  import bps_pkg::*;
  localparam int PD = 20;
  localparam int TK = OSC_DIV;
  logic        clk, rst_b, en, mskip, rreq, input_undervoltage_lockout, hot, oc, sc;
  logic        oab, obn, obs, win, dro, light, rd, wr, hs_d;
  logic        trip, skc, zc, hs, ls, dis, ssr, ro, roe, wreq;
  logic [3:0]  adr, be;
  logic [4:0]  ton;
  logic [31:0] wd, rdat, q, seed;
  int          fails, n_tests, k, p, rises, r0;
  string       tname;

  bps_buck_pwm_skip_sequencer #(.POR_DELAY_TICKS(PD)) dut_u (
    .mclk_i(clk), .rst_b_i(rst_b), .enable_i(en), .mode_skip_i(mskip),
    .reset_request_in_i(rreq), .input_undervoltage_lockout_i(input_undervoltage_lockout),
    .thermal_hot_i(hot), .pwm_comp_trip_i(trip),
    .overcurrent_comparator_i(oc), .short_circuit_comparator_i(sc),
    .skip_current_comp_i(skc), .out_above_skip_i(oab),
    .out_below_nominal_i(obn), .out_below_skip_i(obs),
    .zero_cross_i(zc), .output_in_window_i(win), .dropout_i(dro),
    .hs_on_o(hs), .ls_on_o(ls), .discharge_o(dis),
    .soft_start_run_o(ssr), .reset_out_o(ro), .reset_out_oe_o(roe),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq));

  bps_stage_model stage_u (
    .mclk_i(clk), .hs_on_i(hs), .ls_on_i(ls), .ton_i(ton),
    .light_i(light), .trip_o(trip), .skip_cur_o(skc), .zc_o(zc));

  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int exp_period(input logic short_i);
    return short_i ? SC_DIVIDE * TK : TK;
  endfunction

  task automatic rnd();
    seed = lfsr(seed);
    ton <= 5'h02 + {2'h0, seed[2:0]};
  endtask

  task automatic tk(input int n);
    repeat (n * TK) @(posedge clk);
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic stat();
    bus(1'b0, REG_STATUS_ADDR, 32'h0, q);
  endtask

  // Clocks between two rises of the high-side drive
  task automatic per(output int n);
    `WT(!hs, 4 * TK)
    `WT(hs, 4 * TK)
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hs === 1'b1 && n < 200);
    do begin
      @(posedge clk);
      n++;
    end while (hs !== 1'b1 && n < 200);
  endtask

  task automatic wake();
    `WT(ssr || hs, (WAKE_TICKS + 3) * TK)
    `CHK({ssr, hs, k >= (WAKE_TICKS - 2) * TK}, 3'b101)
  endtask

  task automatic por();
    `WT(!roe, (PD + 3) * TK)
    `CHK({roe, ro, k >= (PD - 1) * TK}, 3'b001)
  endtask

  task automatic done();
    $display("test %s done", tname);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    hs_d <= hs;
    if (hs === 1'b1 && hs_d !== 1'b1) rises <= rises + 1;
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    finish_test();
  end

  initial begin
    {rst_b, en, mskip, oc, sc, input_undervoltage_lockout, hot} = '0;
    rreq = 1'b0;
    {oab, obn, obs, win, dro, light, rd, wr} = '0;
    adr = 4'h0;
    be = 4'hF;
    wd = 32'h0;
    ton = 5'h04;
    seed = 32'h5C8A;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    tname = "reset";
    `CHK({hs, ls, dis, roe}, 4'b0011)
    done();
    tname = "wake";
    en <= 1'b1;
    mskip <= 1'b1;
    wake();
    done();
    tname = "pwm";
    rnd();
    per(p);
    `CHK(p, exp_period(1'b0))
    `WT(hs, 2 * TK)
    `WT(!hs, 40)
    `CHK({hs, ls, k <= ton + 6}, 3'b011)
    `WT(!ls, 2 * TK)
    `CHK(hs, 1'b1)
    done();
    tname = "force";
    bus(1'b0, REG_CTRL_ADDR, 32'h0, q);
    `CHK(q, 32'h0)
    be <= 4'hE;
    bus(1'b1, REG_CTRL_ADDR, 32'h1, q);
    be <= 4'hF;
    bus(1'b0, REG_CTRL_ADDR, 32'h0, q);
    `CHK(q, 32'h0)
    bus(1'b1, REG_CTRL_ADDR, 32'h1, q);
    bus(1'b0, REG_CTRL_ADDR, 32'h0, q);
    `CHK(q, 32'h1)
    bus(1'b0, 4'h8, 32'h0, q);
    `CHK(q, 32'h0)
    light <= 1'b1;
    tk(12);
    stat();
    `CHK(q[STAT_SKIP_BIT], 1'b0)
    bus(1'b1, REG_CTRL_ADDR, 32'h0, q);
    mskip <= 1'b0;
    tk(12);
    stat();
    `CHK(q[STAT_SKIP_BIT], 1'b0)
    done();
    tname = "zcount";
    light <= 1'b0;
    mskip <= 1'b1;
    tk(2);
    stat();
    `CHK(q[STAT_ZC_LSB +: 4], 4'h0)
    light <= 1'b1;
    tk(5);
    stat();
    `CHK(q[STAT_SKIP_BIT], 1'b0)
    `CHK(q[STAT_ZC_LSB +: 4] > 4'h2, 1'b1)
    tk(6);
    stat();
    `CHK(q[STAT_SKIP_BIT], 1'b1)
    done();
    tname = "skip";
    ton <= 5'h14;
    `WT(!hs, 2 * TK)
    `WT(hs, 2 * TK)
    `WT(!hs, 2 * TK)
    `CHK(k <= 10, 1'b1)
    oab <= 1'b1;
    repeat (8) @(posedge clk);
    r0 = rises;
    tk(3);
    `CHK({rises == r0, ls}, 2'b10)
    oab <= 1'b0;
    obn <= 1'b1;
    `WT(hs, TK + 8)
    `CHK(hs, 1'b1)
    obn <= 1'b0;
    obs <= 1'b1;
    light <= 1'b0;
    repeat (8) @(posedge clk);
    stat();
    `CHK(q[STAT_SKIP_BIT], 1'b0)
    obs <= 1'b0;
    done();
    tname = "short";
    rnd();
    sc <= 1'b1;
    per(p);
    per(p);
    `CHK(p, exp_period(1'b1))
    sc <= 1'b0;
    ton <= 5'h19;
    `WT(!hs, 4 * TK)
    `WT(hs, 4 * TK)
    oc <= 1'b1;
    `WT(!hs, 8)
    `CHK({hs, k <= 6}, 2'b01)
    oc <= 1'b0;
    rnd();
    dro <= 1'b1;
    tk(2);
    r0 = rises;
    tk(2);
    `CHK({hs, rises == r0}, 2'b11)
    dro <= 1'b0;
    done();
    tname = "por";
    `CHK(roe, 1'b1)
    win <= 1'b1;
    por();
    rreq <= 1'b1;
    `WT(roe, 6)
    r0 = rises;
    tk(PD + 2);
    `CHK({roe, rises > r0}, 2'b11)
    rreq <= 1'b0;
    por();
    done();
    tname = "faults";
    light <= 1'b1;
    tk(4);
    input_undervoltage_lockout <= 1'b1;
    repeat (8) @(posedge clk);
    r0 = rises;
    tk(2);
    `CHK({hs, ls, roe, rises == r0}, 4'b0011)
    hot <= 1'b1;
    input_undervoltage_lockout <= 1'b0;
    light <= 1'b0;
    tk(2);
    `CHK({hs, ls, ssr, roe}, 4'b0001)
    stat();
    `CHK({q[STAT_SKIP_BIT], q[STAT_ZC_LSB +: 4]}, 5'h00)
    hot <= 1'b0;
    sc <= 1'b1;
    wake();
    sc <= 1'b0;
    `CHK(roe, 1'b1)
    en <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK({hs, ls, dis, roe}, 4'b0011)
    done();
    finish_test();
  end
endmodule
